// ===== tb/bsp_bus_master.sv
// Behavioural supervisory master: sends request characters, collects answers
`timescale 1ns/1ps
module bsp_bus_master #(
  parameter int BIT = 1041
) (
  input wire logic clk,
  output logic line_out,
  input wire logic line_in
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  // Fixed 9600 bit/s, 8 bits, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      line_out <= b[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Sampled mid-bit; the caller waits for the whole answer before sending again
  always
  begin
    @(negedge line_in);
    repeat (BIT + BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      sh[i] = line_in;
      repeat (BIT) @(posedge clk);
    end
    got.push_back(sh);
  end
endmodule

// ===== tb/bsp_checker.sv
// Port checker for the serial point-map endpoint
`timescale 1ns/1ps
module bsp_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic rs485_tx,
  input wire logic rs485_tx_oe_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic inverter_running,
  input wire logic [15:0] ref_freq,
  input wire logic [15:0] high_frequency_limit,
  input wire logic [15:0] low_frequency_limit,
  input wire logic param_wr_strobe
);
  localparam int CHAR_MIN = 10409;
  localparam int CHAR_MAX = 10411;
  logic [8:0] cfg_reg;
  logic [7:0] stn_reg;
  int low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Shadows of what software wrote, so link gating can be judged
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_reg <= bsp_pkg::CONFIG_RST;
      stn_reg <= bsp_pkg::STATION_RST;
      low_cnt <= 0;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == bsp_pkg::RA_CONFIG)
        cfg_reg <= reg_wdata[8:0];
      if (reg_wr && reg_addr == bsp_pkg::RA_STATION && !inverter_running)
        stn_reg <= reg_wdata[7:0];
      low_cnt <= rs485_tx_oe_n ? 0 : low_cnt + 1;
    end
  end
  sequence s_stn_rd;
    reg_rd && reg_addr == bsp_pkg::RA_STATION;
  endsequence
  sequence s_char_start;
    $fell(rs485_tx_oe_n);
  endsequence
  chk_unmapped_zero: assert property (reg_rd && reg_addr > bsp_pkg::RA_PARAM_RD
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_station_lock: assert property (s_stn_rd |=> reg_rdata == {8'h00, stn_reg})
    else $error("station address wrong");
  chk_cfg_readback: assert property (reg_rd && reg_addr == bsp_pkg::RA_CONFIG
    |=> reg_rdata == {7'h00, cfg_reg}) else $error("config readback wrong");
  chk_proto_gate: assert property (s_char_start
    |-> cfg_reg[3:0] == bsp_pkg::PROTO_POINT_MAP) else $error("sent while disabled");
  chk_ref_gate: assert property ($changed(ref_freq) |-> cfg_reg[8])
    else $error("reference taken without source");
  chk_start_bit: assert property (s_char_start |-> !rs485_tx [*8])
    else $error("start bit missing");
  chk_idle_high: assert property (rs485_tx_oe_n |-> rs485_tx)
    else $error("line not idle high");
  chk_char_len: assert property ($rose(rs485_tx_oe_n) |-> low_cnt inside {[CHAR_MIN:CHAR_MAX]})
    else $error("character length wrong");
  chk_freq_limits: assert property (high_frequency_limit <= bsp_pkg::FREQ_LIMIT_MAX
    && low_frequency_limit <= bsp_pkg::FREQ_LIMIT_MAX) else $error("limit above max");
  chk_strobe_pulse: assert property (param_wr_strobe |=> !param_wr_strobe)
    else $error("strobe too long");
endmodule
bind bsp_point_map bsp_checker u_chk (.clk(clk), .srst(srst), .ce(ce), .rs485_tx(rs485_tx),
  .rs485_tx_oe_n(rs485_tx_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inverter_running(inverter_running),
  .ref_freq(ref_freq), .high_frequency_limit(high_frequency_limit),
  .low_frequency_limit(low_frequency_limit), .param_wr_strobe(param_wr_strobe));

// ===== tb/bsp_point_map_test.sv
// Self-checking bench for the serial point-map endpoint
`timescale 1ns/1ps
module bsp_point_map_test;
  logic clk, srst, ce, rx, tx, oe_n, reg_wr, reg_rd, running;
  logic [15:0] run_sw, out_sw;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] alarm_a;
  int fails, samples_checked, cycles;
  logic [7:0] req [10] = '{8'h3e, 8'h30, 8'h35, 8'h31, 8'h31, 8'h30, 8'h36, 8'h32, 8'h44, 8'h0d};
  logic [7:0] rsp [8] = '{8'h41, 8'h30, 8'h30, 8'h46, 8'h46, 8'h45, 8'h43, 8'h0d};
  // Released driver leaves the bus to its idle-high bias
  wire line = oe_n ? 1'b1 : tx;
  bsp_point_map u_dut (.clk(clk), .srst(srst), .ce(ce), .rs485_rx(rx), .rs485_tx(tx),
    .rs485_tx_oe_n(oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inverter_running(running),
    .run_status_word(run_sw), .output_status_word(out_sw), .latest_alarm_code(alarm_a),
    .previous_alarm_code(8'h12), .voltage_input_monitor(16'h4e20),
    .current_input_monitor(16'h2710), .second_voltage_input_monitor(16'h1388),
    .param_rd_data(16'h0abc), .ref_freq(), .accel_time(), .decel_time(),
    .high_frequency_limit(), .low_frequency_limit(), .param_rd_num(), .param_wr_num(),
    .param_wr_data(), .param_wr_strobe());
  bsp_bus_master u_master (.clk(clk), .line_out(rx), .line_in(line));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    // Leave on an edge so the next request starts right after it
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 250000)
    begin
      fails++;
      end_of_test;
    end
  end
  initial
  begin
    {reg_wr, reg_rd, running} = 3'b000;
    ce = 1'b1;
    run_sw = 16'h0903;
    out_sw = 16'h0007;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    alarm_a = 8'hff;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(bsp_pkg::RA_CONFIG, 16'h0000);
    rd(bsp_pkg::RA_STATION, 16'h0001);
    rd(4'hf, 16'h0000);
    wr(bsp_pkg::RA_CONFIG, 16'h0123);
    rd(bsp_pkg::RA_CONFIG, 16'h0123);
    running <= 1'b1;
    wr(bsp_pkg::RA_STATION, 16'h0005);
    rd(bsp_pkg::RA_STATION, 16'h0001);
    running <= 1'b0;
    wr(bsp_pkg::RA_STATION, 16'h0005);
    rd(bsp_pkg::RA_STATION, 16'h0005);
    // A write while the clock enable is low must leave the configuration alone
    ce <= 1'b0;
    wr(bsp_pkg::RA_CONFIG, 16'h0000);
    ce <= 1'b1;
    rd(bsp_pkg::RA_CONFIG, 16'h0123);
    // Read of the latest alarm code at station 5; 0xff is the top of its range
    foreach (req[i]) u_master.send_byte(req[i]);
    for (int n = 0; n < 200000 && u_master.got.size() < 8; n++)
      @(posedge clk);
    foreach (rsp[i]) check({8'h00, u_master.got[i]}, {8'h00, rsp[i]});
    repeat (2083) @(posedge clk);
    rd(bsp_pkg::RA_STATUS, 16'h0201);
    end_of_test;
  end
endmodule

// ===== verilog/bsp_pkg.sv
// Constants, point map, character codes and register map for the serial point-map endpoint
package bsp_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int BAUD_BPS = 9600;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] PROTO_POINT_MAP = 4'h3;
  localparam logic [3:0] BAUD_CODE_9600 = 4'h2;
  // Frame characters
  localparam logic [7:0] CH_SOF = 8'h3e;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ACK = 8'h41;
  localparam logic [7:0] CH_NAK = 8'h4e;
  localparam logic [7:0] CMD_READ = 8'h31;
  localparam logic [7:0] CMD_WRITE = 8'h32;
  localparam logic [7:0] RGN_AI = 8'h31;
  localparam logic [7:0] RGN_BI = 8'h32;
  localparam logic [7:0] RGN_AO = 8'h33;
  localparam logic [7:0] ASCII_MASK = 8'h7f;
  // Request layout, character positions after the start character
  localparam int REQ_MAX = 12;
  localparam logic [3:0] LEN_READ = 4'h8;
  localparam logic [3:0] LEN_WRITE = 4'hc;
  localparam int POS_ADDR = 0;
  localparam int POS_CMD = 2;
  localparam int POS_RGN = 3;
  localparam int POS_POINT = 4;
  localparam int POS_DATA = 6;
  localparam logic [3:0] LEN_RESP_READ = 4'h8;
  localparam logic [3:0] LEN_RESP_SHORT = 4'h2;
  // Point numbers
  localparam logic [7:0] AI_ALARM_LATEST = 8'h06;
  localparam logic [7:0] AI_ALARM_PREV = 8'h07;
  localparam logic [7:0] AI_VOLT_IN = 8'h0c;
  localparam logic [7:0] AI_CURR_IN = 8'h0d;
  localparam logic [7:0] AI_VOLT2_IN = 8'h0e;
  localparam logic [7:0] AI_PARAM_DATA = 8'h0f;
  localparam logic [7:0] BI_FORWARD = 8'h01;
  localparam logic [7:0] BI_REVERSE = 8'h02;
  localparam logic [7:0] BI_TRIP = 8'h03;
  localparam logic [7:0] BI_FARR = 8'h04;
  localparam logic [7:0] BI_FDET = 8'h05;
  localparam logic [7:0] BI_READY = 8'h06;
  localparam logic [7:0] BI_ILIM = 8'h09;
  localparam logic [7:0] BI_ACCEL = 8'h0a;
  localparam logic [7:0] BI_DECEL = 8'h0b;
  localparam logic [7:0] AO_REF_FREQ = 8'h01;
  localparam logic [7:0] AO_ACCEL = 8'h07;
  localparam logic [7:0] AO_DECEL = 8'h08;
  localparam logic [7:0] AO_FREQ_HIGH = 8'h0a;
  localparam logic [7:0] AO_FREQ_LOW = 8'h0b;
  localparam logic [7:0] AO_PARAM_RD_NUM = 8'h0f;
  localparam logic [7:0] AO_PARAM_WR_NUM = 8'h10;
  localparam logic [7:0] AO_PARAM_WR_DATA = 8'h11;
  // Status word bit positions
  localparam int RS_FORWARD = 0;
  localparam int RS_REVERSE = 1;
  localparam int RS_ILIM = 8;
  localparam int RS_ACCEL = 9;
  localparam int RS_DECEL = 10;
  localparam int RS_TRIP = 11;
  localparam int OS_FARR = 0;
  localparam int OS_FDET = 1;
  localparam int OS_READY = 2;
  // 120.0 Hz in 0.1 Hz units
  localparam logic [15:0] FREQ_LIMIT_MAX = 16'h04b0;
  // Parameter group codes (upper byte of the parameter number)
  localparam logic [7:0] GRP_RESERVED = 8'h00;
  localparam logic [7:0] GRP_COMMAND = 8'h02;
  localparam logic [7:0] GRP_MONITOR = 8'h03;
  localparam logic [7:0] GRP_FUNDAMENTAL = 8'h04;
  localparam logic [7:0] GRP_LINK = 8'h0f;
  // Software register map
  localparam logic [3:0] RA_CONFIG = 4'h0;
  localparam logic [3:0] RA_STATION = 4'h1;
  localparam logic [3:0] RA_STATUS = 4'h2;
  localparam logic [3:0] RA_REF_FREQ = 4'h3;
  localparam logic [3:0] RA_PARAM_RD = 4'h4;
  localparam int CFG_PROTO_LSB = 0;
  localparam int CFG_BAUD_LSB = 4;
  localparam int CFG_CMDSRC_BIT = 8;
  localparam logic [8:0] CONFIG_RST = 9'h000;
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [2:0] {ST_HUNT, ST_COLLECT, ST_EXEC, ST_SEND, ST_WAIT} bsp_state_e;
endpackage

// ===== verilog/bsp_point_map.sv
// Serial slave endpoint: frame handling, point map and software registers
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// How it works
// - The link runs only at 9600 bit/s; baud selector must hold code 2.
// - Characters are 8 data bits of 7-bit ASCII, one stop bit, no parity.
// - Half-duplex slave: answer only after a request; master waits for answer.
// - Frames are handled only while the protocol selector holds 3.
// - Reference frequency is taken only when command source allows this link.
// - Station address comes from its register; changes refused while running.
// - Analog inputs 6 and 7 give latest and previous alarm codes, 0 to 255.
// - Analog inputs 12, 13, 14 give scaled terminal voltage and current inputs.
// - Bit inputs 4, 5, 6 show output status word bits 0, 1, 2.
// - Bit inputs 1-3 and 9-11 show run status bits 0,1,11 and 8,9,10.
// - Analog outputs 10 and 11 set frequency limits, accepted from 0 to 120.0 Hz.
// - Parameter access: read number at point 15, write number 16, data 17.
// - Parameter number upper byte is its group code; group 0 is refused.
module bsp_point_map (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic rs485_rx,
  output logic rs485_tx,
  output logic rs485_tx_oe_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic inverter_running,
  input wire logic [15:0] run_status_word,
  input wire logic [15:0] output_status_word,
  input wire logic [7:0] latest_alarm_code,
  input wire logic [7:0] previous_alarm_code,
  input wire logic [15:0] voltage_input_monitor,
  input wire logic [15:0] current_input_monitor,
  input wire logic [15:0] second_voltage_input_monitor,
  input wire logic [15:0] param_rd_data,
  output logic [15:0] ref_freq,
  output logic [15:0] accel_time,
  output logic [15:0] decel_time,
  output logic [15:0] high_frequency_limit,
  output logic [15:0] low_frequency_limit,
  output logic [15:0] param_rd_num,
  output logic [15:0] param_wr_num,
  output logic [15:0] param_wr_data,
  output logic param_wr_strobe
);
  function automatic logic [3:0] hex_to_nib(input logic [7:0] c);
    hex_to_nib = (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  function automatic logic [7:0] nib_to_hex(input logic [3:0] n);
    nib_to_hex = (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
  endfunction

  logic rx_meta_reg;
  logic rx_sync_reg;
  logic [8:0] config_reg;
  logic [7:0] station_reg;
  logic [7:0] answered_reg;
  logic [15:0] rdata_reg;
  logic [7:0] buf_reg [0:bsp_pkg::REQ_MAX-1];
  logic [3:0] cnt_reg;
  bsp_pkg::bsp_state_e state_reg;
  logic [15:0] rsp_val_reg;
  logic rsp_ack_reg;
  logic rsp_long_reg;
  logic [3:0] idx_reg;
  logic [15:0] ref_reg;
  logic [15:0] acc_reg;
  logic [15:0] dec_reg;
  logic [15:0] fhi_reg;
  logic [15:0] flo_reg;
  logic [15:0] prd_reg;
  logic [15:0] pwn_reg;
  logic [15:0] pwd_reg;
  logic pws_reg;

  logic rx_valid;
  logic [7:0] rx_raw;
  logic tx_busy;
  logic tx_start;
  logic [7:0] tx_char;

  // Pin input passes two flip-flops before anything reads it
  always_ff @(posedge clk)
    if (srst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else if (ce)
    begin
      rx_meta_reg <= rs485_rx;
      rx_sync_reg <= rx_meta_reg;
    end

  wire [3:0] proto_sel = config_reg[bsp_pkg::CFG_PROTO_LSB +: 4];
  wire [3:0] baud_sel = config_reg[bsp_pkg::CFG_BAUD_LSB +: 4];
  wire cmd_src_link = config_reg[bsp_pkg::CFG_CMDSRC_BIT];
  wire link_en = proto_sel == bsp_pkg::PROTO_POINT_MAP
    && baud_sel == bsp_pkg::BAUD_CODE_9600;
  wire listening = state_reg == bsp_pkg::ST_HUNT || state_reg == bsp_pkg::ST_COLLECT;

  bsp_uart u_uart (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .rx_line(rx_sync_reg),
    .rx_enable(link_en && listening),
    .rx_valid(rx_valid),
    .rx_byte(rx_raw),
    .tx_start(tx_start),
    .tx_byte(tx_char),
    .tx_busy(tx_busy),
    .tx_line(rs485_tx)
  );

  // Driver enabled only while a character is on the wire
  assign rs485_tx_oe_n = ~tx_busy;

  wire [7:0] rx_char = rx_raw & bsp_pkg::ASCII_MASK;

  // Request decode
  wire [7:0] req_addr = {hex_to_nib(buf_reg[bsp_pkg::POS_ADDR]),
    hex_to_nib(buf_reg[bsp_pkg::POS_ADDR+1])};
  wire [7:0] req_cmd = buf_reg[bsp_pkg::POS_CMD];
  wire [7:0] req_rgn = buf_reg[bsp_pkg::POS_RGN];
  wire [7:0] req_pt = {hex_to_nib(buf_reg[bsp_pkg::POS_POINT]),
    hex_to_nib(buf_reg[bsp_pkg::POS_POINT+1])};
  wire [15:0] req_data = {hex_to_nib(buf_reg[bsp_pkg::POS_DATA]),
    hex_to_nib(buf_reg[bsp_pkg::POS_DATA+1]),
    hex_to_nib(buf_reg[bsp_pkg::POS_DATA+2]),
    hex_to_nib(buf_reg[bsp_pkg::POS_DATA+3])};
  wire [3:0] chk_pos = cnt_reg - 4'h2;
  wire [7:0] req_chk = {hex_to_nib(buf_reg[chk_pos]), hex_to_nib(buf_reg[chk_pos + 4'h1])};
  wire is_read = req_cmd == bsp_pkg::CMD_READ && cnt_reg == bsp_pkg::LEN_READ;
  wire is_write = req_cmd == bsp_pkg::CMD_WRITE && cnt_reg == bsp_pkg::LEN_WRITE
    && req_rgn == bsp_pkg::RGN_AO;

  logic [7:0] sum;
  always_comb
  begin
    sum = 8'h00;
    for (int i = 0; i < bsp_pkg::REQ_MAX; i++)
      if (4'(i) < chk_pos)
        sum = sum + buf_reg[i];
  end

  // A frame is silently dropped when any of these fail
  wire frame_ok = sum == req_chk && req_addr == station_reg
    && (is_read || is_write);

  // Read side of the point map
  logic [15:0] rd_val;
  logic rd_ok;
  always_comb
  begin
    rd_val = 16'h0000;
    rd_ok = 1'b1;
    if (req_rgn == bsp_pkg::RGN_AI)
      case (req_pt)
        bsp_pkg::AI_ALARM_LATEST: rd_val = {8'h00, latest_alarm_code};
        bsp_pkg::AI_ALARM_PREV: rd_val = {8'h00, previous_alarm_code};
        bsp_pkg::AI_VOLT_IN: rd_val = voltage_input_monitor;
        bsp_pkg::AI_CURR_IN: rd_val = current_input_monitor;
        bsp_pkg::AI_VOLT2_IN: rd_val = second_voltage_input_monitor;
        bsp_pkg::AI_PARAM_DATA: rd_val = param_rd_data;
        default: rd_ok = 1'b0;
      endcase
    else if (req_rgn == bsp_pkg::RGN_BI)
      case (req_pt)
        bsp_pkg::BI_FORWARD: rd_val[0] = run_status_word[bsp_pkg::RS_FORWARD];
        bsp_pkg::BI_REVERSE: rd_val[0] = run_status_word[bsp_pkg::RS_REVERSE];
        bsp_pkg::BI_TRIP: rd_val[0] = run_status_word[bsp_pkg::RS_TRIP];
        bsp_pkg::BI_FARR: rd_val[0] = output_status_word[bsp_pkg::OS_FARR];
        bsp_pkg::BI_FDET: rd_val[0] = output_status_word[bsp_pkg::OS_FDET];
        bsp_pkg::BI_READY: rd_val[0] = output_status_word[bsp_pkg::OS_READY];
        bsp_pkg::BI_ILIM: rd_val[0] = run_status_word[bsp_pkg::RS_ILIM];
        bsp_pkg::BI_ACCEL: rd_val[0] = run_status_word[bsp_pkg::RS_ACCEL];
        bsp_pkg::BI_DECEL: rd_val[0] = run_status_word[bsp_pkg::RS_DECEL];
        default: rd_ok = 1'b0;
      endcase
    else if (req_rgn == bsp_pkg::RGN_AO)
      case (req_pt)
        bsp_pkg::AO_REF_FREQ: rd_val = ref_reg;
        bsp_pkg::AO_ACCEL: rd_val = acc_reg;
        bsp_pkg::AO_DECEL: rd_val = dec_reg;
        bsp_pkg::AO_FREQ_HIGH: rd_val = fhi_reg;
        bsp_pkg::AO_FREQ_LOW: rd_val = flo_reg;
        bsp_pkg::AO_PARAM_RD_NUM: rd_val = prd_reg;
        bsp_pkg::AO_PARAM_WR_NUM: rd_val = pwn_reg;
        bsp_pkg::AO_PARAM_WR_DATA: rd_val = pwd_reg;
        default: rd_ok = 1'b0;
      endcase
    else
      rd_ok = 1'b0;
  end

  // Write acceptance; a refused write leaves every output register alone
  wire grp_ok = req_data[15:8] != bsp_pkg::GRP_RESERVED;
  wire lim_ok = req_data <= bsp_pkg::FREQ_LIMIT_MAX;
  wire pw_grp_ok = pwn_reg[15:8] != bsp_pkg::GRP_RESERVED;
  logic wr_ok;
  always_comb
    case (req_pt)
      bsp_pkg::AO_REF_FREQ: wr_ok = cmd_src_link;
      bsp_pkg::AO_ACCEL, bsp_pkg::AO_DECEL: wr_ok = 1'b1;
      bsp_pkg::AO_FREQ_HIGH, bsp_pkg::AO_FREQ_LOW: wr_ok = lim_ok;
      bsp_pkg::AO_PARAM_RD_NUM, bsp_pkg::AO_PARAM_WR_NUM: wr_ok = grp_ok;
      bsp_pkg::AO_PARAM_WR_DATA: wr_ok = pw_grp_ok;
      default: wr_ok = 1'b0;
    endcase

  wire exec = state_reg == bsp_pkg::ST_EXEC && frame_ok;
  wire do_wr = exec && is_write && wr_ok;

  always_ff @(posedge clk)
    if (srst)
    begin
      ref_reg <= bsp_pkg::WORD_RST;
      acc_reg <= bsp_pkg::WORD_RST;
      dec_reg <= bsp_pkg::WORD_RST;
      fhi_reg <= bsp_pkg::WORD_RST;
      flo_reg <= bsp_pkg::WORD_RST;
      prd_reg <= bsp_pkg::WORD_RST;
      pwn_reg <= bsp_pkg::WORD_RST;
      pwd_reg <= bsp_pkg::WORD_RST;
      pws_reg <= 1'b0;
    end
    else if (ce)
    begin
      pws_reg <= do_wr && req_pt == bsp_pkg::AO_PARAM_WR_DATA;
      if (do_wr)
        case (req_pt)
          bsp_pkg::AO_REF_FREQ: ref_reg <= req_data;
          bsp_pkg::AO_ACCEL: acc_reg <= req_data;
          bsp_pkg::AO_DECEL: dec_reg <= req_data;
          bsp_pkg::AO_FREQ_HIGH: fhi_reg <= req_data;
          bsp_pkg::AO_FREQ_LOW: flo_reg <= req_data;
          bsp_pkg::AO_PARAM_RD_NUM: prd_reg <= req_data;
          bsp_pkg::AO_PARAM_WR_NUM: pwn_reg <= req_data;
          bsp_pkg::AO_PARAM_WR_DATA: pwd_reg <= req_data;
          default: pwd_reg <= pwd_reg;
        endcase
    end

  assign ref_freq = ref_reg;
  assign accel_time = acc_reg;
  assign decel_time = dec_reg;
  assign high_frequency_limit = fhi_reg;
  assign low_frequency_limit = flo_reg;
  assign param_rd_num = prd_reg;
  assign param_wr_num = pwn_reg;
  assign param_wr_data = pwd_reg;
  assign param_wr_strobe = pws_reg;

  // Response characters: ack/nak, then four hex value digits and checksum for a good read only, then CR
  wire [7:0] v0 = nib_to_hex(rsp_val_reg[15:12]);
  wire [7:0] v1 = nib_to_hex(rsp_val_reg[11:8]);
  wire [7:0] v2 = nib_to_hex(rsp_val_reg[7:4]);
  wire [7:0] v3 = nib_to_hex(rsp_val_reg[3:0]);
  wire [7:0] rsp_sum = v0 + v1 + v2 + v3;
  wire [3:0] rsp_len = rsp_long_reg ? bsp_pkg::LEN_RESP_READ : bsp_pkg::LEN_RESP_SHORT;
  wire rsp_last = idx_reg == rsp_len - 4'h1;
  always_comb
    if (idx_reg == 4'h0)
      tx_char = rsp_ack_reg ? bsp_pkg::CH_ACK : bsp_pkg::CH_NAK;
    else if (rsp_last)
      tx_char = bsp_pkg::CH_CR;
    else
      case (idx_reg)
        4'h1: tx_char = v0;
        4'h2: tx_char = v1;
        4'h3: tx_char = v2;
        4'h4: tx_char = v3;
        4'h5: tx_char = nib_to_hex(rsp_sum[7:4]);
        default: tx_char = nib_to_hex(rsp_sum[3:0]);
      endcase

  assign tx_start = state_reg == bsp_pkg::ST_SEND;

  always_ff @(posedge clk)
    if (srst)
    begin
      state_reg <= bsp_pkg::ST_HUNT;
      cnt_reg <= 4'h0;
      idx_reg <= 4'h0;
      rsp_val_reg <= bsp_pkg::WORD_RST;
      rsp_ack_reg <= 1'b0;
      rsp_long_reg <= 1'b0;
      answered_reg <= 8'h00;
    end
    else if (ce)
      case (state_reg)
        bsp_pkg::ST_HUNT:
          if (rx_valid && rx_char == bsp_pkg::CH_SOF)
          begin
            cnt_reg <= 4'h0;
            state_reg <= bsp_pkg::ST_COLLECT;
          end
        bsp_pkg::ST_COLLECT:
          if (!link_en)
            state_reg <= bsp_pkg::ST_HUNT;
          else if (rx_valid)
          begin
            // A new start character restarts the frame
            if (rx_char == bsp_pkg::CH_SOF)
              cnt_reg <= 4'h0;
            else if (rx_char == bsp_pkg::CH_CR)
              state_reg <= bsp_pkg::ST_EXEC;
            else if (cnt_reg == 4'(bsp_pkg::REQ_MAX))
              state_reg <= bsp_pkg::ST_HUNT;
            else
              cnt_reg <= cnt_reg + 4'h1;
          end
        bsp_pkg::ST_EXEC:
        begin
          idx_reg <= 4'h0;
          rsp_val_reg <= rd_val;
          rsp_ack_reg <= is_read ? rd_ok : wr_ok;
          rsp_long_reg <= is_read && rd_ok;
          state_reg <= frame_ok ? bsp_pkg::ST_SEND : bsp_pkg::ST_HUNT;
          if (frame_ok)
            answered_reg <= answered_reg + 8'h01;
        end
        bsp_pkg::ST_SEND:
          state_reg <= bsp_pkg::ST_WAIT;
        bsp_pkg::ST_WAIT:
          if (!tx_busy)
          begin
            idx_reg <= idx_reg + 4'h1;
            state_reg <= rsp_last ? bsp_pkg::ST_HUNT : bsp_pkg::ST_SEND;
          end
        default:
          state_reg <= bsp_pkg::ST_HUNT;
      endcase

  always_ff @(posedge clk)
    if (srst)
      buf_reg <= '{default: 8'h00};
    else if (ce && state_reg == bsp_pkg::ST_COLLECT && rx_valid
      && rx_char != bsp_pkg::CH_SOF && rx_char != bsp_pkg::CH_CR
      && cnt_reg < 4'(bsp_pkg::REQ_MAX))
      buf_reg[cnt_reg] <= rx_char;

  // Software registers
  wire busy = state_reg != bsp_pkg::ST_HUNT;
  logic [15:0] rd_mux;
  always_comb
    case (reg_addr)
      bsp_pkg::RA_CONFIG: rd_mux = {7'h00, config_reg};
      bsp_pkg::RA_STATION: rd_mux = {8'h00, station_reg};
      bsp_pkg::RA_STATUS: rd_mux = {6'h00, link_en, busy, answered_reg};
      bsp_pkg::RA_REF_FREQ: rd_mux = ref_reg;
      bsp_pkg::RA_PARAM_RD: rd_mux = prd_reg;
      default: rd_mux = 16'h0000;
    endcase

  always_ff @(posedge clk)
    if (srst)
    begin
      config_reg <= bsp_pkg::CONFIG_RST;
      station_reg <= bsp_pkg::STATION_RST;
      rdata_reg <= 16'h0000;
    end
    else if (ce)
    begin
      rdata_reg <= reg_rd ? rd_mux : 16'h0000;
      if (reg_wr && reg_addr == bsp_pkg::RA_CONFIG)
        config_reg <= reg_wdata[8:0];
      // Changing address mid-operation would orphan the master's polls
      if (reg_wr && reg_addr == bsp_pkg::RA_STATION && !inverter_running)
        station_reg <= reg_wdata[7:0];
    end

  assign reg_rdata = rdata_reg;
endmodule

// ===== verilog/bsp_uart.sv
// Fixed-format 8N1 serial receiver and transmitter
`timescale 1ns/1ps
module bsp_uart #(
  parameter int BIT_CYCLES = bsp_pkg::CLK_HZ / bsp_pkg::BAUD_BPS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic rx_line,
  input wire logic rx_enable,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_line
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);
  localparam logic [3:0] LAST_BIT = 4'(bsp_pkg::DATA_BITS + 1);

  logic rx_act_reg;
  logic [CW-1:0] rx_tmr_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_valid_reg;
  logic [CW-1:0] tx_tmr_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  logic tx_busy_reg;
  wire rx_tick = rx_tmr_reg == '0;
  wire tx_tick = tx_tmr_reg == '0;
  wire rx_stop = rx_bit_reg == LAST_BIT;
  wire tx_last = tx_bit_reg == LAST_BIT;

  assign rx_valid = rx_valid_reg;
  assign rx_byte = rx_sh_reg;
  assign tx_busy = tx_busy_reg;
  assign tx_line = tx_busy_reg ? tx_sh_reg[0] : 1'b1;

  // Start bit is checked again at mid-bit so glitches do not start a character
  always_ff @(posedge clk)
    if (srst)
    begin
      rx_act_reg <= 1'b0;
      rx_tmr_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid_reg <= 1'b0;
      if (!rx_act_reg)
      begin
        rx_bit_reg <= 4'h0;
        rx_tmr_reg <= HALF;
        rx_act_reg <= rx_enable && !rx_line;
      end
      else if (!rx_tick)
        rx_tmr_reg <= rx_tmr_reg - 1'b1;
      else
      begin
        rx_tmr_reg <= FULL;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_line)
          rx_act_reg <= 1'b0;
        else if (rx_stop)
        begin
          rx_act_reg <= 1'b0;
          rx_valid_reg <= rx_line;
        end
        else if (rx_bit_reg != 4'h0)
          rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
      end
    end

  always_ff @(posedge clk)
    if (srst)
    begin
      tx_busy_reg <= 1'b0;
      tx_tmr_reg <= '0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
    end
    else if (ce)
    begin
      if (!tx_busy_reg)
      begin
        if (tx_start)
        begin
          tx_busy_reg <= 1'b1;
          tx_tmr_reg <= FULL;
          tx_bit_reg <= 4'h0;
          tx_sh_reg <= {1'b1, tx_byte, 1'b0};
        end
      end
      else if (!tx_tick)
        tx_tmr_reg <= tx_tmr_reg - 1'b1;
      else
      begin
        tx_tmr_reg <= FULL;
        tx_bit_reg <= tx_bit_reg + 4'h1;
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        if (tx_last)
          tx_busy_reg <= 1'b0;
      end
    end
endmodule
